// [verilog/potc_defines.svh]
// Register offsets, field positions, reset values and counts of the panel output timing stage.
// Assumes a 12-bit APB byte address; included by the package and every design module.
`ifndef POTC_DEFINES_SVH
`define POTC_DEFINES_SVH
`define POTC_ADDR_W          12
`define POTC_DATA_W          18
`define POTC_OFS_FIRST       12'h400
`define POTC_OFS_SECOND      12'h404
`define POTC_OFS_STATUS      12'h408
`define POTC_RST_FIRST       32'h0000_0000
`define POTC_RST_SECOND      32'h0000_0000
`define POTC_MASK_FIRST      32'h27FF_00FF
`define POTC_MASK_SECOND     32'h6DC0_2000
`define POTC_F1_IN_POL       29
`define POTC_F1_LEAD_HI      7
`define POTC_F1_LEAD_LO      5
`define POTC_F1_TRAIL_HI     4
`define POTC_F1_TRAIL_LO     0
`define POTC_F2_BYPASS       30
`define POTC_F2_STROBE_POL   29
`define POTC_F2_SHIFT_MODE   27
`define POTC_F2_LINE_SEL     26
`define POTC_F2_TFT          24
`define POTC_F2_VPOL         23
`define POTC_F2_HPOL         22
`define POTC_F2_DISP_ONLY    13
`define POTC_CNT_MAX         5'h1F
`define POTC_LEAD_STEP       5'h01
`endif

// [verilog/potc_pkg.sv]
// Types and shared arithmetic of the panel output timing stage.
// Assumes potc_defines.svh is on the include path.
`include "potc_defines.svh"
package potc_pkg;
  typedef struct packed {
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] rdata;
  } potc_reg_state_t;

  typedef struct packed {
    logic       prev_sync;
    logic       running;
    logic [4:0] count;
    logic       pulse;
  } potc_gen_state_t;

  // Leading edge offset in dot clocks: code 0 means none, codes 1..7 mean 2..8.
  function automatic logic [4:0] potc_lead_offset(input logic [2:0] code);
    potc_lead_offset = (code == 3'h0) ? 5'h00 : ({2'h0, code} + `POTC_LEAD_STEP);
  endfunction
endpackage

// [verilog/potc_apb_regs.sv]
// APB slave holding the two panel timing registers and a read-only status word.
// Assumes a zero-wait master; pready is always high and unmapped addresses answer pslverr.
`timescale 1ns/10ps
`include "potc_defines.svh"
module potc_apb_regs (
  // Clock and reset.
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave.
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`POTC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Register contents and status.
  input  wire logic [31:0]              status_word,
  output logic      [31:0]              timing_first,
  output logic      [31:0]              timing_second
);
  import potc_pkg::*;

  potc_reg_state_t q;
  potc_reg_state_t next_q;
  logic            mapped;

  always_comb begin
    mapped = (paddr == `POTC_OFS_FIRST) || (paddr == `POTC_OFS_SECOND) || (paddr == `POTC_OFS_STATUS);
    next_q = q;
    // Read data is fetched in the setup cycle so that it is registered by the access cycle.
    if (psel && !penable) begin
      unique case (paddr)
        `POTC_OFS_FIRST:  next_q.rdata = q.first;
        `POTC_OFS_SECOND: next_q.rdata = q.second;
        `POTC_OFS_STATUS: next_q.rdata = status_word;
        default:          next_q.rdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && paddr == `POTC_OFS_FIRST) begin
      next_q.first = pwdata & `POTC_MASK_FIRST;
    end
    if (psel && penable && pwrite && paddr == `POTC_OFS_SECOND) begin
      next_q.second = pwdata & `POTC_MASK_SECOND;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{first: `POTC_RST_FIRST, second: `POTC_RST_SECOND, rdata: 32'h0000_0000};
    end else begin
      q <= next_q;
    end
  end

  assign prdata        = q.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !mapped;
  assign timing_first  = q.first;
  assign timing_second = q.second;
endmodule

// [verilog/potc_line_sync_gen.sv]
// Output line sync shaper: counts dot clocks from each modified input sync rising edge.
// Assumes pix_rise is a one-cycle pulse per dot clock and line_sync_mod is already synchronised.
`timescale 1ns/10ps
`include "potc_defines.svh"
module potc_line_sync_gen (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Timing inputs.
  input  wire logic       pix_rise,
  input  wire logic       line_sync_mod,
  // Configuration.
  input  wire logic       honour,
  input  wire logic [2:0] lead_code,
  input  wire logic [4:0] trail_pos,
  // Result.
  output logic            pulse,
  output logic [4:0]      count
);
  import potc_pkg::*;

  potc_gen_state_t q;
  potc_gen_state_t next_q;
  logic [4:0]      lead;

  always_comb begin
    lead   = potc_lead_offset(lead_code);
    next_q = q;
    if (pix_rise) begin
      next_q.prev_sync = line_sync_mod;
      if (line_sync_mod && !q.prev_sync) begin
        next_q.count   = 5'h00;
        next_q.running = 1'b1;
      end else if (q.running && q.count != `POTC_CNT_MAX) begin
        next_q.count = q.count + `POTC_LEAD_STEP;
      end
      // Without the enable both edge fields are ignored and the input pulse passes as is.
      if (honour) begin
        next_q.pulse = next_q.running && (next_q.count >= lead) && (next_q.count < trail_pos);
      end else begin
        next_q.pulse = line_sync_mod;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{prev_sync: 1'b0, running: 1'b0, count: 5'h00, pulse: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign pulse = q.pulse;
  assign count = q.count;

  a_no_short_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pix_rise && honour && trail_pos <= potc_lead_offset(lead_code) |=> !pulse)
    else $error("pulse emitted for zero or negative length setting");
  a_trail_edge_end: assert property (@(posedge pclk) disable iff (!presetn)
    pix_rise && honour && q.running && q.count != `POTC_CNT_MAX && q.count + `POTC_LEAD_STEP == trail_pos
    && !(line_sync_mod && !q.prev_sync) |=> !pulse)
    else $error("pulse still high at trailing edge count");
  a_follow_input: assert property (@(posedge pclk) disable iff (!presetn)
    pix_rise && !honour |=> pulse == $past(line_sync_mod))
    else $error("pulse does not follow input while edge fields are ignored");
endmodule

// [verilog/potc_top.sv]
// Panel output timing stage: reshapes line sync, sets output polarities, gates the shift clock.
// Assumes the dot clock and all panel-side inputs are asynchronous to pclk and slower than pclk/2.
`timescale 1ns/10ps
`include "potc_defines.svh"
module potc_top #(
  parameter int DATA_W = `POTC_DATA_W
) (
  // Clock and reset.
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave.
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`POTC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Pixel stream from the graphics source, asynchronous to pclk.
  input  wire logic                     pixel_clock,
  input  wire logic                     input_line_sync,
  input  wire logic                     input_frame_sync,
  input  wire logic                     input_data_enable,
  input  wire logic [DATA_W-1:0]        input_pixel_data,
  // Panel pins.
  output logic                          panel_shift_clock,
  output logic                          line_pin,
  output logic                          frame_sync_out,
  output logic                          display_data_strobe,
  output logic      [DATA_W-1:0]        panel_pixel_data
);
  import potc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [3:0]        meta;
    logic [3:0]        sync;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    logic              pix_prev;
    logic              frame_disp;
    logic              shift;
    logic              line;
    logic              frame;
    logic              strobe;
    logic [DATA_W-1:0] data;
  } potc_top_state_t;

  potc_top_state_t q;
  potc_top_state_t next_q;

  logic [31:0] timing_first;
  logic [31:0] timing_second;
  logic [31:0] status_word;
  logic        pix_s;
  logic        line_s;
  logic        frame_s;
  logic        de_s;
  logic        pix_rise;
  logic        line_mod;
  logic        gen_pulse;
  logic [4:0]  gen_count;
  logic        bypass;
  logic        tft;
  logic        strobe_pol;
  logic        shift_mode;
  logic        line_sel;
  logic        vpol;
  logic        hpol;
  logic        disp_only;
  logic        shift_free;
  logic        lp_gate;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  potc_apb_regs u_regs (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .status_word   (status_word),
    .timing_first  (timing_first),
    .timing_second (timing_second)
  );

  assign bypass     = timing_second[`POTC_F2_BYPASS];
  assign strobe_pol = timing_second[`POTC_F2_STROBE_POL];
  assign shift_mode = timing_second[`POTC_F2_SHIFT_MODE];
  assign line_sel   = timing_second[`POTC_F2_LINE_SEL];
  assign tft        = timing_second[`POTC_F2_TFT];
  assign vpol       = timing_second[`POTC_F2_VPOL];
  assign hpol       = timing_second[`POTC_F2_HPOL];
  assign disp_only  = timing_second[`POTC_F2_DISP_ONLY];

  // Status shows the display-seen flag, the shaped pulse and the dot clock count.
  assign status_word = 32'({q.frame_disp, gen_pulse, gen_count});

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised panel-side inputs.

  assign pix_s    = q.sync[3];
  assign line_s   = q.sync[2];
  assign frame_s  = q.sync[1];
  assign de_s     = q.sync[0];
  assign pix_rise = pix_s && !q.pix_prev;
  assign line_mod = line_s ^ timing_first[`POTC_F1_IN_POL];

  ////////////////////////////////////////////////////////////////////////////////
  // Line sync shaping.

  potc_line_sync_gen u_gen (
    .pclk          (pclk),
    .presetn       (presetn),
    .pix_rise      (pix_rise),
    .line_sync_mod (line_mod),
    .honour        (shift_mode),
    .lead_code     (timing_first[`POTC_F1_LEAD_HI:`POTC_F1_LEAD_LO]),
    .trail_pos     (timing_first[`POTC_F1_TRAIL_HI:`POTC_F1_TRAIL_LO]),
    .pulse         (gen_pulse),
    .count         (gen_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output formation.

  // Outside bypass only TFT panels may run the shift clock through retrace; STN keeps it gated.
  assign shift_free = tft && shift_mode;
  // Line pulses are suppressed outside display only on STN with the display-only bit.
  assign lp_gate    = tft || !disp_only || q.frame_disp;

  always_comb begin
    next_q           = q;
    next_q.meta      = {pixel_clock, input_line_sync, input_frame_sync, input_data_enable};
    next_q.sync      = q.meta;
    next_q.data_meta = input_pixel_data;
    next_q.data_sync = q.data_meta;
    next_q.pix_prev  = pix_s;
    // A frame counts as displaying from its first data enable until the next frame sync.
    if (de_s) begin
      next_q.frame_disp = 1'b1;
    end else if (frame_s) begin
      next_q.frame_disp = 1'b0;
    end
    if (bypass) begin
      next_q.shift  = pix_s;
      next_q.line   = line_s;
      next_q.frame  = frame_s;
      next_q.strobe = de_s;
      next_q.data   = q.data_sync;
    end else begin
      next_q.shift  = pix_s && (shift_free || de_s);
      if (line_sel) begin
        next_q.line = gen_pulse ^ hpol;
      end else begin
        next_q.line = gen_pulse && lp_gate;
      end
      next_q.frame  = frame_s ^ (tft && vpol);
      next_q.strobe = ~(de_s ^ strobe_pol);
      next_q.data   = q.data_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign panel_shift_clock   = q.shift;
  assign line_pin            = q.line;
  assign frame_sync_out      = q.frame;
  assign display_data_strobe = q.strobe;
  assign panel_pixel_data    = q.data;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_bypass_line_pass: assert property (@(posedge pclk) disable iff (!presetn)
    bypass |=> line_pin == $past(line_s) && frame_sync_out == $past(frame_s))
    else $error("bypass does not pass input timing to the panel");

  a_bypass_data_pass: assert property (@(posedge pclk) disable iff (!presetn)
    bypass ##1 bypass |=> panel_pixel_data == $past(input_pixel_data, 3))
    else $error("bypass pixel data not forwarded");

  a_strobe_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && !strobe_pol && de_s |=> !display_data_strobe)
    else $error("data strobe not active low with polarity bit clear");

  a_strobe_high: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && strobe_pol |=> display_data_strobe == $past(de_s))
    else $error("data strobe not active high with polarity bit set");

  a_shift_stn_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && !tft && !de_s |=> !panel_shift_clock)
    else $error("shift clock toggles outside display on STN");

  a_shift_free_run: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && tft && shift_mode |=> panel_shift_clock == $past(pix_s))
    else $error("free running shift clock stopped");

  a_frame_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && tft && vpol |=> frame_sync_out == !$past(frame_s))
    else $error("frame sync not inverted in TFT mode");

  a_line_sync_pol: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && line_sel |=> line_pin == ($past(gen_pulse) ^ $past(hpol)))
    else $error("line sync polarity wrong");

  a_lp_display_only: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && !line_sel && !tft && disp_only && !q.frame_disp |=> !line_pin)
    else $error("line pulse outside display time");

  a_lp_continuous: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && !line_sel && !disp_only |=> line_pin == $past(gen_pulse))
    else $error("continuous line pulse missing");

  a_lead_edge_pos: assert property (@(posedge pclk) disable iff (!presetn)
    pix_rise && shift_mode && line_mod && !u_gen.q.prev_sync
    && timing_first[`POTC_F1_LEAD_HI:`POTC_F1_LEAD_LO] == 3'h0
    && timing_first[`POTC_F1_TRAIL_HI:`POTC_F1_TRAIL_LO] != 5'h00 |=> gen_pulse)
    else $error("zero leading edge code did not assert at once");

  a_bypass_strobe_pass: assert property (@(posedge pclk) disable iff (!presetn)
    bypass |=> display_data_strobe == $past(de_s) && panel_shift_clock == $past(pix_s))
    else $error("bypass does not pass strobe and shift clock to the panel");

  a_lp_gate_path: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && !line_sel |=> line_pin == ($past(gen_pulse) && $past(lp_gate)))
    else $error("line pulse does not follow the gated shaped pulse");

  a_frame_stn_plain: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && !tft |=> frame_sync_out == $past(frame_s))
    else $error("frame sync polarity changed outside TFT mode");

  a_frame_tft_high: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && tft && !vpol |=> frame_sync_out == $past(frame_s))
    else $error("frame sync not active high in TFT mode");

  a_shift_tft_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && tft && !shift_mode |=> panel_shift_clock == ($past(pix_s) && $past(de_s)))
    else $error("shift clock not gated by display period");

  a_disp_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    de_s |=> q.frame_disp)
    else $error("display flag not set by data enable");

  a_disp_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    frame_s && !de_s |=> !q.frame_disp)
    else $error("display flag not cleared by frame sync");

  a_strobe_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && !strobe_pol && !de_s |=> display_data_strobe)
    else $error("active low data strobe not idle high");

  a_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> timing_second == `POTC_RST_SECOND)
    else $error("second timing register not cleared by reset");

  a_write_second: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == `POTC_OFS_SECOND |=> timing_second == ($past(pwdata) & `POTC_MASK_SECOND))
    else $error("write to second timing register did not land");

  a_write_first: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == `POTC_OFS_FIRST |=> timing_first == ($past(pwdata) & `POTC_MASK_FIRST))
    else $error("write to first timing register did not land");

  a_line_sync_high: assert property (@(posedge pclk) disable iff (!presetn)
    !bypass && line_sel && !hpol |=> line_pin == $past(gen_pulse))
    else $error("line sync not active high with polarity bit clear");
endmodule

// [verif/potc_pixel_src.sv]
// Source model of the pixel stream: dot clock, line and frame sync, data enable.
// Assumes go is held high by the bench until busy falls; the dot clock stands still between runs.
`timescale 1ns/10ps
module potc_pixel_src #(
  parameter int N_DOT  = 40,
  parameter int SYNC_W = 4,
  parameter int DE_B   = 8,
  parameter int DE_E   = 36
) (
  // Control from the bench.
  input  wire logic go,
  input  wire logic pol,
  output logic      busy,
  // Stream towards the timing stage.
  output logic      pixel_clock,
  output logic      input_line_sync,
  output logic      input_frame_sync,
  output logic      input_data_enable
);
  logic raw_sync;
  // The wire level of the line sync follows the polarity that software programs.
  assign input_line_sync = raw_sync ^ pol;
  initial begin
    busy              = 1'b0;
    pixel_clock       = 1'b0;
    raw_sync          = 1'b0;
    input_frame_sync  = 1'b0;
    input_data_enable = 1'b0;
    forever begin
      wait (go === 1'b1);
      busy = 1'b1;
      #13;
      for (int l = 0; l < 2; l++) begin
        for (int d = 0; d < N_DOT; d++) begin
          // Timing lines change only while the dot clock is low.
          raw_sync          = (d < SYNC_W);
          input_frame_sync  = (l == 0) && (d < 2);
          input_data_enable = (d >= DE_B) && (d < DE_E);
          #40 pixel_clock = 1'b1;
          #40 pixel_clock = 1'b0;
        end
      end
      busy = 1'b0;
      wait (go === 1'b0);
    end
  end
endmodule

// [verif/potc_top_tb.sv]
// Self-checking bench of the panel output timing stage: APB master, source model, cycle monitor.
// Assumes the design files and potc_defines.svh; two lines of 40 dots are sent per configuration.
`timescale 1ns/10ps
`include "potc_defines.svh"
module potc_top_tb;
  localparam int SYNC_W = 4;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`POTC_ADDR_W-1:0]  paddr;
  logic [31:0]              pwdata, prdata, lf_d = 32'h0000_0003, lf_r, rd, f, s;
  logic                     pixel_clock, input_line_sync, input_frame_sync, input_data_enable;
  logic [`POTC_DATA_W-1:0]  input_pixel_data, panel_pixel_data;
  logic                     panel_shift_clock, line_pin, frame_sync_out, display_data_strobe;
  logic                     go, src_pol, src_busy, meas, byp_chk, err;
  logic                     lact, sact, fact, lp_prev, sc_prev;
  logic [`POTC_DATA_W-1:0]  hist [4];
  int                       n_errors, n_tests, n_act, n_rise, n_str, n_fs, n_tog, cyc, t_in, t_out;
  int                       b27 [12] = '{0, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0};
  int                       lead [12] = '{3, 0, 1, 7, 3, 5, 0, 2, 0, 0, 0, 0};
  int                       trl [12] = '{9, 3, 5, 31, 4, 2, 1, 9, 0, 0, 0, 0};
  int                       tft [12] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 1, 0};
  int                       dsp [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0};

  potc_top u_potc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_clock(pixel_clock), .input_line_sync(input_line_sync), .input_frame_sync(input_frame_sync),
    .input_data_enable(input_data_enable), .input_pixel_data(input_pixel_data),
    .panel_shift_clock(panel_shift_clock), .line_pin(line_pin), .frame_sync_out(frame_sync_out),
    .display_data_strobe(display_data_strobe), .panel_pixel_data(panel_pixel_data));
  potc_pixel_src u_potc_pixel_src (.go(go), .pol(src_pol), .busy(src_busy), .pixel_clock(pixel_clock),
    .input_line_sync(input_line_sync), .input_frame_sync(input_frame_sync),
    .input_data_enable(input_data_enable));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Holds each request until pready is sampled high, then takes data and response.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_lines();
    int k;
    {n_act, n_rise, n_str, n_fs, n_tog, cyc} = '0;
    t_in  = -1;
    t_out = -1;
    @(posedge pclk);
    meas <= 1'b1;
    go   <= 1'b1;
    repeat (5) @(posedge pclk);
    k = 0;
    while (src_busy === 1'b1 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (src_busy === 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: source model still busy", $time);
    end
    repeat (20) @(posedge pclk);
    meas    <= 1'b0;
    go      <= 1'b0;
    byp_chk <= 1'b0;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
  // Cycle monitor of the panel pins and bypass data check.
  always @(posedge pclk) begin
    if (meas) begin
      cyc++;
      if (line_pin === lact) n_act++;
      if (line_pin === lact && lp_prev !== lact && t_out < 0) t_out = cyc;
      if (line_pin === lact && lp_prev !== lact) n_rise++;
      if (input_line_sync === !src_pol && t_in < 0) t_in = cyc;
      if (display_data_strobe === sact) n_str++;
      if (frame_sync_out === fact) n_fs++;
      if (panel_shift_clock !== sc_prev) n_tog++;
    end
    lp_prev = line_pin;
    sc_prev = panel_shift_clock;
    if (byp_chk) chk(panel_pixel_data, hist[3]);
    for (int k = 3; k > 0; k--) hist[k] = hist[k-1];
    lf_d = lfsr(lf_d);
    hist[0] = lf_d[`POTC_DATA_W-1:0];
    input_pixel_data <= lf_d[`POTC_DATA_W-1:0];
  end

  initial begin
    int lo, dots, lines;
    logic sp, sel, hp, vp, byp;
    {psel, penable, pwrite, paddr, pwdata, go, src_pol, meas, byp_chk} = '0;
    lf_r = 32'h0000_0003;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `POTC_OFS_FIRST, 32'h0);
    chk(rd, `POTC_RST_FIRST);
    apb(1'b0, `POTC_OFS_SECOND, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `POTC_OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h40C, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    apb(1'b0, 12'h40C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    lf_r = lfsr(lf_r);
    apb(1'b1, `POTC_OFS_FIRST, lf_r);
    apb(1'b0, `POTC_OFS_FIRST, 32'h0);
    chk(rd, lf_r & `POTC_MASK_FIRST);
    apb(1'b1, `POTC_OFS_SECOND, ~lf_r);
    apb(1'b0, `POTC_OFS_SECOND, 32'h0);
    chk(rd, ~lf_r & `POTC_MASK_SECOND);
    for (int i = 0; i < 12; i++) begin
      lf_r = lfsr(lf_r);
      byp = (i == 11);
      sp  = lf_r[29];
      sel = (tft[i] == 1);
      hp  = lf_r[22];
      vp  = lf_r[23];
      f = (32'(i % 2) << 29) | (32'(lead[i]) << 5) | 32'(trl[i]);
      s = (32'(byp) << 30) | (32'(sp) << 29) | (32'(b27[i]) << 27) | (32'(sel) << 26) | (32'(tft[i]) << 24);
      s = s | (32'(vp) << 23) | (32'(hp) << 22) | (32'(dsp[i]) << 13);
      src_pol <= (i % 2 == 1);
      apb(1'b1, `POTC_OFS_FIRST, f);
      apb(1'b1, `POTC_OFS_SECOND, s);
      lo    = (b27[i] == 0 || lead[i] == 0) ? 0 : lead[i] + 1;
      dots  = (b27[i] == 0) ? SYNC_W : ((trl[i] > lo) ? trl[i] - lo : 0);
      lines = (dsp[i] == 1 && tft[i] == 0) ? 1 : 2;
      lact  = byp ? (i % 2 == 0) : (sel ? !hp : 1'b1);
      sact  = byp ? 1'b1 : sp;
      fact  = (tft[i] == 1 && !byp) ? !vp : 1'b1;
      byp_chk <= byp;
      run_lines();
      chk(n_act, lines * dots * 10);
      chk(n_rise, (dots > 0) ? lines : 0);
      if (dots > 0 && lines == 2 && !byp) chk(t_out - t_in inside {[lo * 10 + 4 : lo * 10 + 13]}, 1'b1);
      chk(n_str, 560);
      chk(n_fs, 20);
      if (byp || (tft[i] == 1 && b27[i] == 1)) chk(n_tog inside {[156 : 160]}, 1'b1);
      else chk(n_tog inside {[108 : 116]}, 1'b1);
    end
    apb(1'b0, `POTC_OFS_STATUS, 32'h0);
    chk(rd, {25'h0, 1'b1, 1'b0, `POTC_CNT_MAX});
    stop_test();
  end
endmodule
